// >>> hw/spcs_pkg.sv
`default_nettype none
package spcs_pkg;
  // Register addresses in direct SFR space
  localparam logic [7:0] ADDR_PAGE_CONTROL = 8'h84;
  localparam logic [7:0] ADDR_ACTIVE_PAGE = 8'hA7;
  localparam logic [7:0] ADDR_STACK_SECOND = 8'h85;
  // Bottom entry address is not fixed here; module parameter default
  localparam logic [7:0] ADDR_STACK_BOTTOM_DEF = 8'h86;
  // Page on which the control register lives
  localparam logic [7:0] PAGE_CONTROL_HOME = 8'h0F;
  // Pages loaded on vectoring
  localparam logic [7:0] PAGE_DEFAULT = 8'h00;
  localparam logic [7:0] PAGE_CAN = 8'h0C;
  // Control register layout and reset
  localparam int CTRL_EN_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [7:0] ENTRY_RESET = 8'h00;

  // Register access request from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } spcs_sfr_req_t;

  // Interrupt entry and return strobes
  typedef struct packed {
    logic entry;
    logic is_can;
    logic ret;
  } spcs_irq_evt_t;
endpackage
`default_nettype wire

// >>> hw/spcs_page_stack.sv
`default_nettype none
// What this block does
// - Interrupt entry pushes top and second down
// - Entry then loads the source's page
// - Vector page 0x00, controller interrupt 0x0C
// - Return pops second to top, bottom up
// - Empty bottom pops zero into second
// - Register writes never push or pop
// - Second and bottom writable during service
// - Nested push overwrites bottom unconditionally
// - Active page writable unless an enabled entry or return fires that cycle, second and bottom likewise
// - All three entries readable and writable
// - Control bit 0 enables auto paging
// - Enable bit resets to one
// - Control bits 7:1 read zero
// - Control decodes at 0x84 on page 0x0F
// - All-page registers decode on any page
// - Active page at 0xA7, resets zero
// - Second entry at 0x85, resets zero
module spcs_page_stack #(
  parameter logic [7:0] ADDR_STACK_BOTTOM = spcs_pkg::ADDR_STACK_BOTTOM_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire spcs_pkg::spcs_sfr_req_t sfr_req,
  input wire spcs_pkg::spcs_irq_evt_t irq_evt,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  output logic [7:0] active_page,
  output logic auto_page_enable
);

  // Stack entries and enable bit
  logic [7:0] active_page_reg, active_page_next;
  logic [7:0] page_stack_second_reg, page_stack_second_next;
  logic [7:0] page_stack_bottom_reg, page_stack_bottom_next;
  logic auto_page_enable_reg, auto_page_enable_next;
  // Address decode strobes
  logic sel_ctrl, sel_top, sel_second, sel_bottom;
  logic [7:0] vec_page;
  logic [7:0] rdata_next;
  logic [7:0] sfr_rdata_reg;

  // Address decode
  always_comb begin
    sel_ctrl = (sfr_req.addr == spcs_pkg::ADDR_PAGE_CONTROL)
      && (active_page_reg == spcs_pkg::PAGE_CONTROL_HOME);
    sel_top = (sfr_req.addr == spcs_pkg::ADDR_ACTIVE_PAGE);
    sel_second = (sfr_req.addr == spcs_pkg::ADDR_STACK_SECOND);
    sel_bottom = (sfr_req.addr == ADDR_STACK_BOTTOM);
  end

  // Next-state for stack and control
  always_comb begin
    active_page_next = active_page_reg;
    page_stack_second_next = page_stack_second_reg;
    page_stack_bottom_next = page_stack_bottom_reg;
    auto_page_enable_next = auto_page_enable_reg;
    vec_page = irq_evt.is_can ? spcs_pkg::PAGE_CAN : spcs_pkg::PAGE_DEFAULT;
    // software writes touch one entry only
    if (sfr_req.wr) begin
      if (sel_top) begin
        active_page_next = sfr_req.wdata;
      end
      if (sel_second) begin
        page_stack_second_next = sfr_req.wdata;
      end
      if (sel_bottom) begin
        page_stack_bottom_next = sfr_req.wdata;
      end
      if (sel_ctrl) begin
        auto_page_enable_next = sfr_req.wdata[spcs_pkg::CTRL_EN_BIT];
      end
    end
    // stack moves only when enabled; event wins over write
    if (auto_page_enable_reg) begin
      if (irq_evt.entry) begin
        page_stack_bottom_next = page_stack_second_reg;
        page_stack_second_next = active_page_reg;
        active_page_next = vec_page;
      end else if (irq_evt.ret) begin
        active_page_next = page_stack_second_reg;
        page_stack_second_next = page_stack_bottom_reg;
        // bottom emptied; next pop yields zero
        page_stack_bottom_next = spcs_pkg::ENTRY_RESET;
      end
    end
  end

  // Read mux
  always_comb begin
    rdata_next = 8'h00;
    if (!sfr_req.rd) begin
      // No read, data idles at zero
      rdata_next = 8'h00;
    end else if (sel_ctrl) begin
      rdata_next = {7'h00, auto_page_enable_reg};
    end else if (sel_top) begin
      rdata_next = active_page_reg;
    end else if (sel_second) begin
      rdata_next = page_stack_second_reg;
    end else if (sel_bottom) begin
      rdata_next = page_stack_bottom_reg;
    end
  end

  // State registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      active_page_reg <= spcs_pkg::ENTRY_RESET;
      page_stack_second_reg <= spcs_pkg::ENTRY_RESET;
      page_stack_bottom_reg <= spcs_pkg::ENTRY_RESET;
      auto_page_enable_reg <= spcs_pkg::CTRL_RESET[spcs_pkg::CTRL_EN_BIT];
      sfr_rdata_reg <= 8'h00;
    end else begin
      // update lands on the strobe edge
      active_page_reg <= active_page_next;
      page_stack_second_reg <= page_stack_second_next;
      page_stack_bottom_reg <= page_stack_bottom_next;
      auto_page_enable_reg <= auto_page_enable_next;
      sfr_rdata_reg <= rdata_next;
    end
  end

  // Outputs
  assign sfr_rdata = sfr_rdata_reg;
  assign sfr_hit = sel_ctrl | sel_top | sel_second | sel_bottom;
  assign active_page = active_page_reg;
  assign auto_page_enable = auto_page_enable_reg;

  // Push moves top into second and second into bottom
  property p_push;
    @(posedge ref_clk) disable iff (!rst_n)
    (irq_evt.entry && auto_page_enable_reg) |=>
      (page_stack_second_reg == $past(active_page_reg))
      && (page_stack_bottom_reg == $past(page_stack_second_reg));
  endproperty
  a_push: assert property (p_push) else $error("push wrong");

  property p_load;
    @(posedge ref_clk) disable iff (!rst_n)
    (irq_evt.entry && auto_page_enable_reg && irq_evt.is_can) |=> active_page_reg == 8'h0C;
  endproperty
  a_load: assert property (p_load) else $error("can page wrong");

  property p_load_def;
    @(posedge ref_clk) disable iff (!rst_n)
    (irq_evt.entry && auto_page_enable_reg && !irq_evt.is_can) |=> active_page_reg == 8'h00;
  endproperty
  a_load_def: assert property (p_load_def) else $error("default page wrong");

  property p_pop;
    @(posedge ref_clk) disable iff (!rst_n)
    (irq_evt.ret && !irq_evt.entry && auto_page_enable_reg) |=>
      (active_page_reg == $past(page_stack_second_reg))
      && (page_stack_second_reg == $past(page_stack_bottom_reg))
      && (page_stack_bottom_reg == 8'h00);
  endproperty
  a_pop: assert property (p_pop) else $error("pop wrong");

  property p_disabled;
    @(posedge ref_clk) disable iff (!rst_n)
    (!auto_page_enable_reg && !(sfr_req.wr && sfr_hit)) |=> $stable(active_page_reg)
      && $stable(page_stack_second_reg) && $stable(page_stack_bottom_reg);
  endproperty
  a_disabled: assert property (p_disabled) else $error("stack moved when off");

  property p_wr_second;
    @(posedge ref_clk) disable iff (!rst_n)
    (sfr_req.wr && sel_second && !irq_evt.entry && !irq_evt.ret) |=>
      (page_stack_second_reg == $past(sfr_req.wdata)) && $stable(active_page_reg)
      && $stable(page_stack_bottom_reg);
  endproperty
  a_wr_second: assert property (p_wr_second) else $error("second write wrong");

  property p_wr_top;
    @(posedge ref_clk) disable iff (!rst_n)
    (sfr_req.wr && sel_top && !irq_evt.entry && !irq_evt.ret) |=>
      (active_page_reg == $past(sfr_req.wdata)) && $stable(page_stack_second_reg);
  endproperty
  a_wr_top: assert property (p_wr_top) else $error("top write wrong");

  property p_ctrl_read;
    @(posedge ref_clk) disable iff (!rst_n)
    (sfr_req.rd && sel_ctrl) |=> sfr_rdata[7:1] == 7'h00;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("reserved bits set");

  property p_ctrl_page;
    @(posedge ref_clk) disable iff (!rst_n)
    (sfr_req.addr == 8'h84 && active_page_reg != 8'h0F) |-> !sel_ctrl;
  endproperty
  a_ctrl_page: assert property (p_ctrl_page) else $error("control off-page hit");

  property p_wr_bottom;
    @(posedge ref_clk) disable iff (!rst_n)
    (sfr_req.wr && sel_bottom && !irq_evt.entry && !irq_evt.ret) |=>
      (page_stack_bottom_reg == $past(sfr_req.wdata)) && $stable(active_page_reg)
      && $stable(page_stack_second_reg);
  endproperty
  a_wr_bottom: assert property (p_wr_bottom) else $error("bottom write wrong");

  property p_ctrl_write;
    @(posedge ref_clk) disable iff (!rst_n)
    (sfr_req.wr && sel_ctrl) |=> auto_page_enable_reg == $past(sfr_req.wdata[0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("enable write wrong");

  property p_all_pages;
    @(posedge ref_clk) disable iff (!rst_n)
    (sfr_req.addr == 8'hA7 || sfr_req.addr == 8'h85) |-> sfr_hit;
  endproperty
  a_all_pages: assert property (p_all_pages) else $error("page register missed");

  property p_rd_idle;
    @(posedge ref_clk) disable iff (!rst_n)
    !sfr_req.rd |=> sfr_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

endmodule
`default_nettype wire

// >>> dv/spcs_core_model.sv
`default_nettype none
// Core-side strobes into the page stack
module spcs_core_model (
  input wire logic [2:0] go,
  output wire spcs_pkg::spcs_irq_evt_t irq_evt
);
  timeunit 1ns;
  timeprecision 1ps;
  // single-cycle strobes: bits are entry, controller source, return
  assign irq_evt = '{entry: go[2], is_can: go[2] & go[1], ret: go[0]};
endmodule
`default_nettype wire

// >>> dv/spcs_page_stack_tb.sv
`default_nettype none
module spcs_page_stack_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] go = 3'h0;
  spcs_pkg::spcs_sfr_req_t sfr_req = '0;
  spcs_pkg::spcs_irq_evt_t irq_evt;
  logic [7:0] sfr_rdata;
  logic [7:0] active_page;
  logic sfr_hit;
  logic auto_page_enable;
  int num_errors = 0;
  int num_checks = 0;
  // Clock at 100 MHz
  always #5 ref_clk = ~ref_clk;
  spcs_core_model core (.go(go), .irq_evt(irq_evt));
  spcs_page_stack dut (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_req(sfr_req),
    .irq_evt(irq_evt), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .active_page(active_page), .auto_page_enable(auto_page_enable));
  // Counted compare
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk);
    sfr_req.wr <= 1'b0;
  endtask
  // One-cycle read strobe, data the cycle after
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    sfr_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    sfr_req.rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), sfr_rdata, exp);
  endtask
  // One interrupt event through the core model
  task automatic evt(input logic [2:0] g);
    @(posedge ref_clk);
    go <= g;
    @(posedge ref_clk);
    go <= 3'h0;
  endtask
  // Read all three entries back
  task automatic stk(input logic [7:0] t, input logic [7:0] s, input logic [7:0] b);
    rd(8'hA7, t);
    rd(8'h85, s);
    rd(spcs_pkg::ADDR_STACK_BOTTOM_DEF, b);
    chk("active_page", active_page, t);
  endtask
  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard
  initial begin
    #100us;
    num_errors++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    stk(8'h00, 8'h00, 8'h00);
    chk("auto_page_enable", {7'h00, auto_page_enable}, 8'h01);
    rd(8'h84, 8'h00);
    chk("sfr_hit", {7'h00, sfr_hit}, 8'h00);
    wr(8'hA7, 8'h0F);
    rd(8'h84, 8'h01);
    chk("sfr_hit", {7'h00, sfr_hit}, 8'h01);
    wr(8'h84, 8'hFE);
    rd(8'h84, 8'h00);
    chk("auto_page_enable", {7'h00, auto_page_enable}, 8'h00);
    evt(3'b110);
    stk(8'h0F, 8'h00, 8'h00);
    evt(3'b001);
    stk(8'h0F, 8'h00, 8'h00);
    wr(8'h84, 8'h01);
    wr(8'hA7, 8'h05);
    evt(3'b110);
    #1 chk("active_page", active_page, 8'h0C);
    stk(8'h0C, 8'h05, 8'h00);
    wr(spcs_pkg::ADDR_STACK_BOTTOM_DEF, 8'h33);
    stk(8'h0C, 8'h05, 8'h33);
    evt(3'b100);
    stk(8'h00, 8'h0C, 8'h05);
    chk("sfr_hit", {7'h00, sfr_hit}, 8'h01);
    evt(3'b001);
    stk(8'h0C, 8'h05, 8'h00);
    wr(8'h85, 8'h22);
    evt(3'b001);
    stk(8'h22, 8'h00, 8'h00);
    rd(8'h90, 8'h00);
    chk("sfr_hit", {7'h00, sfr_hit}, 8'h00);
    // Dirty every entry and the enable before a second reset
    wr(8'h85, 8'h44);
    wr(spcs_pkg::ADDR_STACK_BOTTOM_DEF, 8'h55);
    wr(8'hA7, 8'h0F);
    wr(8'h84, 8'h00);
    // Second reset in mid-run
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    stk(8'h00, 8'h00, 8'h00);
    chk("auto_page_enable", {7'h00, auto_page_enable}, 8'h01);
    // Control write off its home page is ignored
    wr(8'h84, 8'h00);
    #1 chk("auto_page_enable", {7'h00, auto_page_enable}, 8'h01);
    report_and_stop();
  end
endmodule
`default_nettype wire
